// ==== twg_pkg.sv ====
// Constants and register map for the timing and watchdog unit
`default_nettype none
package twg_pkg;
    // Bus widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CONFIG = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_PRESCALER = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_RELOAD = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 12'h00c;
    localparam logic [ADDR_W-1:0] OFF_WD_COUNT = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_SERVICE = 12'h014;
    // Configuration field positions
    localparam int CFG_LOCK_CONFIG = 0;
    localparam int CFG_LOCK_PRESCALER = 1;
    localparam int CFG_LOCK_TIMER = 2;
    localparam int CFG_LOCK_WD_COUNT = 3;
    localparam int CFG_WD_CLOCK_SELECT = 4;
    localparam int CFG_MATCH_SERVICE = 5;
    localparam int CFG_W = 6;
    // Control and status field positions
    localparam int CSR_RESTART = 0;
    localparam int CSR_TC_FLAG = 1;
    localparam int CSR_IRQ_ENABLE = 2;
    // Divide code
    localparam int DIV_W = 3;
    localparam logic [DIV_W-1:0] DIV_MAX_CODE = 3'h5;
    localparam int PRESC_W = 5;
    // Values after reset
    localparam logic [CFG_W-1:0] RST_CONFIG = 6'h00;
    localparam logic [DIV_W-1:0] RST_DIVIDE = 3'h0;
    localparam logic [15:0] RST_RELOAD = 16'hffff;
    localparam logic [7:0] RST_WD_COUNT = 8'h0f;
    // Service key
    localparam logic [7:0] SERVICE_KEY = 8'h5c;
endpackage
`default_nettype wire

// ==== twg_time_if.sv ====
// Interface joining the core, prescaler and periodic timer
`default_nettype none
interface twg_time_if;
    logic slowEdge;
    logic [twg_pkg::DIV_W-1:0] divCode;
    logic tickPulse;
    logic [15:0] preset;
    logic restartReq;
    logic underflow;
    logic underflowLevel;
    modport pre (input slowEdge, input divCode, output tickPulse);
    modport tmr (input tickPulse, input preset, input restartReq,
                 output underflow, output underflowLevel);
    modport core (output slowEdge, output divCode, output preset,
                  output restartReq, input tickPulse, input underflow,
                  input underflowLevel);
endinterface
`default_nettype wire

// ==== twg_prescaler.sv ====
// Tick clock prescaler dividing slow clock edges by a power of two
`default_nettype none
module twg_prescaler
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Link to core and timer
    twg_time_if.pre tif
);
    import twg_pkg::*;

    typedef struct packed {
        logic [PRESC_W-1:0] cnt;
        logic tick;
    } twg_pre_s;

    twg_pre_s st_r;
    twg_pre_s st_nxt;
    logic [PRESC_W-1:0] lastCount;

    // Terminal count of the divider; reserved codes fall back to one
    always_comb
    begin
        lastCount = '0;
        if (tif.divCode <= DIV_MAX_CODE)
        begin
            lastCount = PRESC_W'((6'h01 << tif.divCode) - 6'h01);
        end
        else
        begin
            lastCount = '0;
        end
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (tif.slowEdge)
        begin
            // A shrunken divisor wraps at once rather than running long
            if (st_r.cnt >= lastCount)
            begin
                st_nxt.cnt = '0;
                st_nxt.tick = 1'b1;
            end
            else
            begin
                st_nxt.cnt = st_r.cnt + 5'h01;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign tif.tickPulse = st_r.tick;
endmodule
`default_nettype wire

// ==== twg_timer.sv ====
// Periodic 16-bit down timer with reload and restart
`default_nettype none
module twg_timer
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Link to core and prescaler
    twg_time_if.tmr tif
);
    import twg_pkg::*;

    typedef struct packed {
        logic [15:0] cnt;
        logic under;
        logic underLevel;
    } twg_tmr_s;

    twg_tmr_s st_r;
    twg_tmr_s st_nxt;

    // Count on each tick; zero reloads and flags an underflow
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.under = 1'b0;
        if (tif.tickPulse)
        begin
            st_nxt.underLevel = 1'b0;
            if (tif.restartReq)
            begin
                st_nxt.cnt = tif.preset;
            end
            else if (st_r.cnt == 16'h0000)
            begin
                st_nxt.cnt = tif.preset;
                st_nxt.under = 1'b1;
                st_nxt.underLevel = 1'b1;
            end
            else
            begin
                st_nxt.cnt = st_r.cnt - 16'h0001;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st_r <= '{cnt: RST_RELOAD, under: 1'b0, underLevel: 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign tif.underflow = st_r.under;
    assign tif.underflowLevel = st_r.underLevel;
endmodule
`default_nettype wire

// ==== twg_timing_guard_unit.sv ====
// Timing and watchdog unit top with APB register slave
//
// Implementation choices: the APB register port and the address map.
`default_nettype none
module twg_timing_guard_unit
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [twg_pkg::ADDR_W-1:0] paddr,
    input wire logic [twg_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [twg_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Slow clock pin and power mode
    input wire logic slowClock,
    input wire logic powerSave,
    // Events out
    output logic timerIrq,
    output logic underflowOut,
    output logic wdResetReq
);
    import twg_pkg::*;

    typedef struct packed {
        logic [CFG_W-1:0] cfg;
        logic [DIV_W-1:0] divCode;
        logic [15:0] reload;
        logic irqEnable;
        logic tcFlag;
        logic restart;
        logic [7:0] wdLoad;
        logic [7:0] watchdog_count;
        logic wdRun;
        logic svcSeen;
        logic wdError;
        logic irq;
        logic underOut;
        logic sync1;
        logic sync2;
        logic sync3;
        logic ready;
        logic [DATA_W-1:0] rdata;
        logic slverr;
    } twg_core_s;

    twg_core_s st_r;
    twg_core_s st_nxt;

    twg_time_if tif ();

    logic accessDone;
    logic accessWait;
    logic addrValid;
    logic regOpen;
    logic doWrite;
    logic doRead;
    logic wdEvent;
    logic [DATA_W-1:0] readValue;
    logic [7:0] wbyte;

    // Tick divider
    twg_prescaler u_prescaler
    (
        .core_clk(core_clk),
        .srst(srst),
        .tif(tif)
    );

    // Periodic timer
    twg_timer u_timer
    (
        .core_clk(core_clk),
        .srst(srst),
        .tif(tif)
    );

    // Signals toward the counting modules
    assign tif.slowEdge = st_r.sync2 & ~st_r.sync3;
    assign tif.divCode = st_r.divCode;
    assign tif.preset = st_r.reload;
    assign tif.restartReq = st_r.restart;

    // APB phase decode; one wait state so the answer comes from flops
    always_comb
    begin
        accessWait = psel && penable && !st_r.ready;
        accessDone = psel && penable && st_r.ready;
        wbyte = pwdata[7:0];
    end

    // Address decode and access gate from lock bits and power mode
    always_comb
    begin
        addrValid = 1'b1;
        regOpen = 1'b0;
        unique case (paddr)
            OFF_CONFIG:
            begin
                regOpen = !st_r.cfg[CFG_LOCK_CONFIG];
            end
            OFF_PRESCALER:
            begin
                regOpen = !st_r.cfg[CFG_LOCK_PRESCALER];
            end
            OFF_RELOAD, OFF_CONTROL:
            begin
                regOpen = !st_r.cfg[CFG_LOCK_TIMER];
            end
            OFF_WD_COUNT:
            begin
                regOpen = !st_r.cfg[CFG_LOCK_WD_COUNT];
            end
            OFF_SERVICE:
            begin
                regOpen = 1'b1;
            end
            default:
            begin
                addrValid = 1'b0;
            end
        endcase
        // Only the service-match register stays reachable in power save
        if (powerSave && (paddr != OFF_SERVICE))
        begin
            regOpen = 1'b0;
        end
        doWrite = accessDone && pwrite && addrValid && regOpen;
        // Read side effects land on the edge that captures the read data
        doRead = accessWait && !pwrite && addrValid && regOpen;
    end

    // Read mux; locked or write-only registers read as zero
    always_comb
    begin
        readValue = '0;
        if (addrValid && regOpen)
        begin
            unique case (paddr)
                OFF_CONFIG:
                begin
                    readValue = DATA_W'(st_r.cfg);
                end
                OFF_PRESCALER:
                begin
                    readValue = DATA_W'(st_r.divCode);
                end
                OFF_RELOAD:
                begin
                    readValue = DATA_W'(st_r.reload);
                end
                OFF_CONTROL:
                begin
                    readValue = DATA_W'({st_r.irqEnable, st_r.tcFlag,
                                         st_r.restart});
                end
                default:
                begin
                    readValue = '0;
                end
            endcase
        end
    end

    // Watchdog clock select between tick and underflow
    always_comb
    begin
        if (st_r.cfg[CFG_WD_CLOCK_SELECT])
        begin
            wdEvent = tif.tickPulse;
        end
        else
        begin
            wdEvent = tif.underflow;
        end
    end

    // Next state of registers, timer status and watchdog
    always_comb
    begin
        st_nxt = st_r;

        // Slow clock pin synchroniser and edge history
        st_nxt.sync1 = slowClock;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sync3 = st_r.sync2;

        // Bus handshake; ready rises at the end of the first access cycle
        st_nxt.ready = accessWait;
        if (accessWait)
        begin
            st_nxt.rdata = pwrite ? '0 : readValue;
            st_nxt.slverr = !addrValid;
        end
        else if (accessDone)
        begin
            st_nxt.rdata = '0;
            st_nxt.slverr = 1'b0;
        end

        // Restart bit drops on the tick that performs it
        if (tif.tickPulse)
        begin
            st_nxt.restart = 1'b0;
        end

        // Clear on read first so a same-cycle underflow wins
        if (doRead && (paddr == OFF_CONTROL))
        begin
            st_nxt.tcFlag = 1'b0;
        end
        if (tif.underflow)
        begin
            st_nxt.tcFlag = 1'b1;
        end

        // Interrupt request pulse per underflow
        st_nxt.irq = tif.underflow && st_r.irqEnable;
        st_nxt.underOut = tif.underflowLevel;

        // Watchdog counting; a zero count on a clock means late service
        if (st_r.wdRun && wdEvent)
        begin
            st_nxt.svcSeen = 1'b0;
            if (st_r.watchdog_count == 8'h00)
            begin
                st_nxt.wdError = 1'b1;
            end
            else
            begin
                st_nxt.watchdog_count = st_r.watchdog_count - 8'h01;
            end
        end

        // Register writes
        if (doWrite && pstrb[0])
        begin
            unique case (paddr)
                OFF_CONFIG:
                begin
                    // Bits only ever get set; clearing needs a reset
                    st_nxt.cfg = st_r.cfg | wbyte[CFG_W-1:0];
                end
                OFF_PRESCALER:
                begin
                    st_nxt.divCode = wbyte[DIV_W-1:0];
                end
                OFF_RELOAD:
                begin
                    st_nxt.reload[7:0] = wbyte;
                end
                OFF_CONTROL:
                begin
                    st_nxt.irqEnable = wbyte[CSR_IRQ_ENABLE];
                    if (wbyte[CSR_RESTART])
                    begin
                        st_nxt.restart = 1'b1;
                    end
                end
                OFF_WD_COUNT:
                begin
                    // Also the service path when match mode is off
                    st_nxt.wdLoad = wbyte;
                    st_nxt.watchdog_count = wbyte;
                    st_nxt.wdRun = 1'b1;
                end
                OFF_SERVICE:
                begin
                    if (st_r.cfg[CFG_MATCH_SERVICE])
                    begin
                        st_nxt.svcSeen = 1'b1;
                        st_nxt.wdRun = 1'b1;
                        if (wbyte != SERVICE_KEY)
                        begin
                            st_nxt.wdError = 1'b1;
                        end
                        else if (st_r.svcSeen && !wdEvent)
                        begin
                            st_nxt.wdError = 1'b1;
                        end
                        else
                        begin
                            st_nxt.watchdog_count = st_r.wdLoad;
                        end
                    end
                    // Ignored entirely while match mode is off
                end
                default:
                begin
                    st_nxt.wdError = st_nxt.wdError;
                end
            endcase
        end
        if (doWrite && pstrb[1] && (paddr == OFF_RELOAD))
        begin
            st_nxt.reload[15:8] = pwdata[15:8];
        end
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st_r.cfg <= RST_CONFIG;
            st_r.divCode <= RST_DIVIDE;
            st_r.reload <= RST_RELOAD;
            st_r.irqEnable <= 1'b0;
            st_r.tcFlag <= 1'b0;
            st_r.restart <= 1'b0;
            st_r.wdLoad <= RST_WD_COUNT;
            st_r.watchdog_count <= RST_WD_COUNT;
            st_r.wdRun <= 1'b0;
            st_r.svcSeen <= 1'b0;
            st_r.wdError <= 1'b0;
            st_r.irq <= 1'b0;
            st_r.underOut <= 1'b0;
            st_r.sync1 <= 1'b0;
            st_r.sync2 <= 1'b0;
            st_r.sync3 <= 1'b0;
            st_r.ready <= 1'b0;
            st_r.rdata <= '0;
            st_r.slverr <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign prdata = st_r.rdata;
    assign pready = st_r.ready;
    assign pslverr = st_r.slverr;
    assign timerIrq = st_r.irq;
    assign underflowOut = st_r.underOut;
    // Error is sticky, so the request lasts until device reset
    assign wdResetReq = st_r.wdError;
endmodule
`default_nettype wire

// ==== twg_timing_guard_unit_chk.sv ====
// Port-level checker for the timing and watchdog unit
`default_nettype none
module twg_timing_guard_unit_chk
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [twg_pkg::ADDR_W-1:0] paddr,
    input wire logic [twg_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [twg_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and events
    input wire logic slowClock,
    input wire logic powerSave,
    input wire logic timerIrq,
    input wire logic underflowOut,
    input wire logic wdResetReq
);
    timeunit 1ns;
    timeprecision 1ns;
    import twg_pkg::*;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (srst);
    logic [CFG_W-1:0] cfg_r;
    logic rdDone;
    logic svcWr;
    // Completed reads and service-match writes
    assign rdDone = pready && !pwrite;
    assign svcWr = pready && pwrite && pstrb[0] && paddr == OFF_SERVICE;
    // Config shadow; bits only set, frozen once the lock bit is up
    always_ff @(posedge core_clk)
        if (srst)
            cfg_r <= '0;
        else if (pready && pwrite && pstrb[0] && !powerSave &&
                 paddr == OFF_CONFIG && !cfg_r[CFG_LOCK_CONFIG])
            cfg_r <= cfg_r | pwdata[CFG_W-1:0];
    a_cfg_readback: assert property (rdDone && paddr == OFF_CONFIG &&
        !cfg_r[CFG_LOCK_CONFIG] && !powerSave |-> prdata == DATA_W'(cfg_r))
        else $error("config readback differs from sticky shadow");
    a_cfg_locked: assert property (rdDone && paddr == OFF_CONFIG &&
        cfg_r[CFG_LOCK_CONFIG] |-> prdata == '0)
        else $error("locked config read not zero");
    a_presc_locked: assert property (rdDone &&
        paddr == OFF_PRESCALER && cfg_r[CFG_LOCK_PRESCALER] |-> prdata == '0)
        else $error("locked prescaler read not zero");
    a_timer_locked: assert property (rdDone &&
        cfg_r[CFG_LOCK_TIMER] &&
        (paddr == OFF_RELOAD || paddr == OFF_CONTROL) |-> prdata == '0)
        else $error("locked timer register read not zero");
    a_psave_read: assert property (rdDone && powerSave |->
        prdata == '0)
        else $error("register readable in power save");
    a_wo_read: assert property (rdDone &&
        (paddr == OFF_WD_COUNT || paddr == OFF_SERVICE) |-> prdata == '0)
        else $error("write-only register read not zero");
    a_bad_key: assert property (svcWr && cfg_r[CFG_MATCH_SERVICE] &&
        pwdata[7:0] != SERVICE_KEY |-> ##[1:3] wdResetReq)
        else $error("wrong service key raised no error");
    a_err_sticky: assert property (wdResetReq |=> wdResetReq)
        else $error("reset request dropped before reset");
    a_irq_cause: assert property (timerIrq |-> ##[0:2] underflowOut)
        else $error("interrupt without underflow");
    a_irq_pulse: assert property (timerIrq |=> !timerIrq)
        else $error("interrupt longer than one cycle");
    a_uf_hold: assert property ($rose(underflowOut) |->
        underflowOut[*4])
        else $error("underflow level too short");
    // Main scenarios reached
    c_match_svc: cover property (svcWr && cfg_r[CFG_MATCH_SERVICE]);
    c_underflow: cover property ($rose(underflowOut));
    c_wd_error: cover property ($rose(wdResetReq));
endmodule
bind twg_timing_guard_unit twg_timing_guard_unit_chk chk_i (.core_clk,
    .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .slowClock, .powerSave, .timerIrq, .underflowOut,
    .wdResetReq);
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the timing and watchdog unit
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import twg_pkg::*;
    localparam int SP = 8; // Slow clock period in core cycles
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'h0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic slowClock = 1'b0;
    logic powerSave = 1'b0;
    logic timerIrq;
    logic underflowOut;
    logic wdResetReq;
    logic [DATA_W-1:0] rdv;
    logic errv;
    int err_total = 0;
    int tests_run = 0;
    always #10 core_clk = ~core_clk;
    // Slow clock edges land on core falling edges, period of SP cycles
    always #80 slowClock = ~slowClock;
    twg_timing_guard_unit dut (.core_clk, .srst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .slowClock,
        .powerSave, .timerIrq, .underflowOut, .wdResetReq);
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge core_clk);
        penable <= 1'b1;
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, '0);
        chk(rdv, exp);
    endtask
    // Error output after the request has had time to land
    task automatic wd(input logic e);
        cyc(4);
        chk(wdResetReq, e);
    endtask
    task automatic do_reset;
        @(posedge core_clk);
        srst <= 1'b1;
        cyc(4);
        srst <= 1'b0;
    endtask
    task automatic rise;
        while (underflowOut !== 1'b0)
            @(posedge core_clk);
        while (underflowOut !== 1'b1)
            @(posedge core_clk);
    endtask
    // Measured fall to fall, well away from the interrupt near the rise
    task automatic meas(input int dv, input logic irqOn);
        int n;
        int hi;
        int irqs;
        n = 0;
        hi = 0;
        irqs = 0;
        rise();
        rise();
        while (underflowOut !== 1'b0)
            @(posedge core_clk);
        do
        begin
            @(posedge core_clk);
            n++;
            hi += int'(underflowOut === 1'b1);
            irqs += int'(timerIrq === 1'b1);
        end
        while (!(hi > 0 && underflowOut === 1'b0));
        chk(n, 4 * dv * SP);
        chk(hi, dv * SP);
        chk(irqs, irqOn);
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #1000000;
        err_total++;
        wrap_up();
    end
    initial
    begin
        int n;
        do_reset();
        // Reset values, write-only and unmapped reads
        rd(OFF_CONFIG, 32'h0);
        rd(OFF_PRESCALER, 32'h0);
        rd(OFF_RELOAD, 32'hffff);
        rd(OFF_CONTROL, 32'h0);
        rd(OFF_WD_COUNT, 32'h0);
        rd(12'h018, 32'h0);
        chk(errv, 1'b1);
        wr(OFF_CONFIG, 32'h10);
        wr(OFF_CONFIG, 32'h00);
        rd(OFF_CONFIG, 32'h10);
        wr(OFF_RELOAD, 32'h3);
        // Every divide code plus a reserved one, interrupt on and off
        for (int i = 0; i < 7; i++)
        begin
            // Restart so the short reload value applies without waiting
            wr(OFF_CONTROL, {29'h0, i[0], 2'h1});
            wr(OFF_PRESCALER, (i == 6) ? 32'h7 : 32'(i));
            meas((i == 6) ? 1 : 1 << i, i[0]);
        end
        rd(OFF_CONTROL, 32'h2);
        rd(OFF_CONTROL, 32'h0);
        wr(OFF_CONTROL, 32'h2);
        rd(OFF_CONTROL, 32'h0);
        // Restart mid-period pushes the next underflow out
        wr(OFF_PRESCALER, 32'h5);
        rise();
        rise();
        cyc(600);
        wr(OFF_CONTROL, 32'h1);
        n = 0;
        repeat (500)
        begin
            @(posedge core_clk);
            n += int'(underflowOut !== 1'b0);
        end
        chk(n, 0);
        rd(OFF_CONTROL, 32'h2);
        powerSave <= 1'b1;
        wr(OFF_PRESCALER, 32'h2);
        rd(OFF_PRESCALER, 32'h0);
        powerSave <= 1'b0;
        rd(OFF_PRESCALER, 32'h5);
        wr(OFF_PRESCALER, 32'h0);
        chk(wdResetReq, 1'b0);
        // Count writes service; service-match writes are ignored
        repeat (4)
        begin
            wr(OFF_WD_COUNT, 32'h5);
            wr(OFF_SERVICE, 32'h11);
            cyc(12);
        end
        chk(wdResetReq, 1'b0);
        cyc(16);
        chk(wdResetReq, 1'b0);
        cyc(40);
        chk(wdResetReq, 1'b1);
        // Match mode on the underflow clock, which stays quiet here
        do_reset();
        wr(OFF_CONFIG, 32'h20);
        wr(OFF_WD_COUNT, 32'h10);
        wr(OFF_SERVICE, 32'h5c);
        wd(1'b0);
        wr(OFF_SERVICE, 32'h5c);
        wd(1'b1);
        do_reset();
        wr(OFF_CONFIG, 32'h20);
        wr(OFF_WD_COUNT, 32'h10);
        wr(OFF_SERVICE, 32'h3a);
        wd(1'b1);
        // A key write alone starts the watchdog from the reset count
        do_reset();
        wr(OFF_CONFIG, 32'h30);
        wr(OFF_SERVICE, 32'h5c);
        cyc(100);
        chk(wdResetReq, 1'b0);
        cyc(40);
        chk(wdResetReq, 1'b1);
        // Match servicing in power save, then full lock
        do_reset();
        wr(OFF_PRESCALER, 32'h1);
        wr(OFF_CONFIG, 32'h30);
        wr(OFF_WD_COUNT, 32'h6);
        powerSave <= 1'b1;
        repeat (5)
        begin
            cyc(14);
            wr(OFF_SERVICE, 32'h5c);
        end
        wd(1'b0);
        powerSave <= 1'b0;
        wr(OFF_CONFIG, 32'h2f);
        rd(OFF_CONFIG, 32'h0);
        rd(OFF_PRESCALER, 32'h0);
        rd(OFF_RELOAD, 32'h0);
        wr(OFF_SERVICE, 32'h5c);
        wr(OFF_WD_COUNT, 32'hff);
        cyc(130);
        chk(wdResetReq, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
